// ### verilog/tpo_pkg.sv
package tpo_pkg;

    // Register byte addresses of the path overhead insertion block.
    localparam logic [15:0] ADDR_PATH_CTRL0   = 16'h1983;
    localparam logic [15:0] ADDR_LABEL_VALUE  = 16'h199F;
    localparam logic [15:0] ADDR_TRACE_CTRL   = 16'h19BB;
    localparam logic [15:0] ADDR_TRACE_VALUE  = 16'h1993;
    localparam logic [15:0] ADDR_INS_STATUS   = 16'h19C0;

    // Field positions.
    localparam int          LABEL_SRC_BIT     = 2;
    localparam logic [7:0]  PATH_CTRL0_MASK   = 8'hFD;
    localparam logic [7:0]  TRACE_CTRL_MASK   = 8'h0F;
    localparam logic [7:0]  RESET_BYTE        = 8'h00;

    // Trace byte source selector encodings.
    localparam logic [1:0]  TRACE_SRC_ZERO    = 2'h0;
    localparam logic [1:0]  TRACE_SRC_BUFFER  = 2'h1;
    localparam logic [1:0]  TRACE_SRC_REG     = 2'h2;
    localparam logic [1:0]  TRACE_SRC_SERIAL  = 2'h3;

    // Overhead port timing: byte and label wait in port clock periods, half-period in system clock cycles.
    localparam int          BITS_PER_BYTE     = 8;
    localparam int          LABEL_WAIT_PERIODS = 16;
    localparam int          OH_CLK_DIV        = 4;

    // Slot spacing, counted in overhead port clock periods.
    localparam int          OH_PERIODS_PER_SLOT = 64;

    typedef enum logic [1:0] {
        TPO_ST_IDLE,
        TPO_ST_WAIT,
        TPO_ST_SHIFT
    } tpo_far_state_t;

endpackage : tpo_pkg

// ### verilog/tpo_link_if.sv
`timescale 1ns/10ps
// Overhead port between the framer device and the external inserter.
interface tpo_link_if;
    logic overhead_port_clock;
    logic overhead_slot_enable;
    logic overhead_frame_marker;
    logic overhead_serial_in;

    modport device (
        output overhead_port_clock,
        output overhead_slot_enable,
        output overhead_frame_marker,
        input  overhead_serial_in
    );

    modport inserter (
        input  overhead_port_clock,
        input  overhead_slot_enable,
        input  overhead_frame_marker,
        output overhead_serial_in
    );
endinterface : tpo_link_if

// ### verilog/tpo_far_inserter.sv
`timescale 1ns/10ps
module tpo_far_inserter (
    input  wire logic       clk,
    input  wire logic       rst,
    tpo_link_if.inserter    link,
    input  wire logic [7:0] trace_byte,
    input  wire logic [7:0] label_byte,
    input  wire logic       label_serial_en,
    output logic            byte_done
);

    logic [2:0]  clk_sync_ff;
    logic [1:0]  en_sync_ff;
    logic [1:0]  fr_sync_ff;
    logic        phase_ff;
    tpo_pkg::tpo_far_state_t state_ff;
    logic [4:0]  wait_ff;
    logic [2:0]  bit_ff;
    logic [7:0]  shreg_ff;
    logic        sdo_ff;
    logic        done_ff;
    logic        rise;
    logic        fall;
    logic        start;

    ////////////////////////////////////////////////////////////////////////
    // The port clock comes from the device, so it and the markers pass two
    // flip-flops before use; edges are found on the synchronised copy.
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_sync_ff <= 3'h0;
            en_sync_ff  <= 2'h0;
            fr_sync_ff  <= 2'h0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[1:0], link.overhead_port_clock};
            en_sync_ff  <= {en_sync_ff[0], link.overhead_slot_enable};
            fr_sync_ff  <= {fr_sync_ff[0], link.overhead_frame_marker};
        end
    end

    assign rise  = clk_sync_ff[1] & ~clk_sync_ff[2];
    assign fall  = ~clk_sync_ff[1] & clk_sync_ff[2];
    assign start = rise & en_sync_ff[1] & fr_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // Remember that both markers were seen; act on the following fall.
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_ff <= 1'b0;
        end else if (start) begin
            phase_ff <= 1'b1;
        end else if (fall) begin
            phase_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift sequencer: the trace byte starts at once, the label byte after
    // the wait, both MSB first, one bit per falling edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= tpo_pkg::TPO_ST_IDLE;
            wait_ff  <= 5'h00;
            bit_ff   <= 3'h0;
            shreg_ff <= 8'h00;
            sdo_ff   <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                tpo_pkg::TPO_ST_IDLE: begin
                    if (fall && phase_ff) begin
                        if (label_serial_en) begin
                            // Label is the third overhead byte.
                            state_ff <= tpo_pkg::TPO_ST_WAIT;
                            wait_ff  <= 5'(tpo_pkg::LABEL_WAIT_PERIODS - 1);
                        end else begin
                            sdo_ff   <= trace_byte[7];
                            shreg_ff <= {trace_byte[6:0], 1'b0};
                            bit_ff   <= 3'h7;
                            state_ff <= tpo_pkg::TPO_ST_SHIFT;
                        end
                    end
                end
                tpo_pkg::TPO_ST_WAIT: begin
                    if (fall) begin
                        if (wait_ff == 5'h00) begin
                            sdo_ff   <= label_byte[7];
                            shreg_ff <= {label_byte[6:0], 1'b0};
                            bit_ff   <= 3'h7;
                            state_ff <= tpo_pkg::TPO_ST_SHIFT;
                        end else begin
                            wait_ff <= wait_ff - 5'h01;
                        end
                    end
                end
                tpo_pkg::TPO_ST_SHIFT: begin
                    if (fall) begin
                        if (bit_ff == 3'h0) begin
                            // Back to watching the markers.
                            state_ff <= tpo_pkg::TPO_ST_IDLE;
                            done_ff  <= 1'b1;
                        end else begin
                            sdo_ff   <= shreg_ff[7];
                            shreg_ff <= {shreg_ff[6:0], 1'b0};
                            bit_ff   <= bit_ff - 3'h1;
                        end
                    end
                end
                default: state_ff <= tpo_pkg::TPO_ST_IDLE;
            endcase
        end
    end

    // No per-byte insert strobe is driven; the selector does the job.
    assign link.overhead_serial_in = sdo_ff;
    assign byte_done               = done_ff;

endmodule : tpo_far_inserter

// ### verilog/tpo_device.sv
`timescale 1ns/10ps
module tpo_device #(
    parameter int CLK_DIV = tpo_pkg::OH_CLK_DIV,
    parameter int SLOT_PERIODS = tpo_pkg::OH_PERIODS_PER_SLOT
) (
    input  wire logic        clk,
    input  wire logic        rst,
    tpo_link_if.device       link,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  trace_buffer_byte,
    output logic      [7:0]  spe_trace_byte,
    output logic      [7:0]  spe_label_byte,
    output logic             spe_update
);

    logic [7:0]  path_ctrl0_ff;
    logic [7:0]  label_value_ff;
    logic [7:0]  trace_ctrl_ff;
    logic [7:0]  trace_value_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  div_ff;
    logic        pclk_ff;
    logic [7:0]  period_ff;
    logic [4:0]  bitpos_ff;
    logic        slot_ff;
    logic [1:0]  sin_sync_ff;
    logic [7:0]  shreg_ff;
    logic [7:0]  serial_trace_ff;
    logic [7:0]  serial_label_ff;
    logic [7:0]  trace_out_ff;
    logic [7:0]  label_out_ff;
    logic        upd_ff;
    logic        rise_tick;
    logic [1:0]  cap_dly_ff;
    logic        cap_tick;
    logic        label_serial;
    logic [4:0]  label_last;

    ////////////////////////////////////////////////////////////////////////
    // Register writes; reserved bits are masked so they read zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            path_ctrl0_ff  <= tpo_pkg::RESET_BYTE;
            label_value_ff <= tpo_pkg::RESET_BYTE;
            trace_ctrl_ff  <= tpo_pkg::RESET_BYTE;
            trace_value_ff <= tpo_pkg::RESET_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                tpo_pkg::ADDR_PATH_CTRL0:
                    path_ctrl0_ff <= reg_wdata & tpo_pkg::PATH_CTRL0_MASK;
                tpo_pkg::ADDR_LABEL_VALUE:
                    label_value_ff <= reg_wdata;
                tpo_pkg::ADDR_TRACE_CTRL:
                    trace_ctrl_ff <= reg_wdata & tpo_pkg::TRACE_CTRL_MASK;
                tpo_pkg::ADDR_TRACE_VALUE:
                    trace_value_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                tpo_pkg::ADDR_PATH_CTRL0:  rdata_ff <= path_ctrl0_ff;
                tpo_pkg::ADDR_LABEL_VALUE: rdata_ff <= label_value_ff;
                tpo_pkg::ADDR_TRACE_CTRL:  rdata_ff <= trace_ctrl_ff;
                tpo_pkg::ADDR_TRACE_VALUE: rdata_ff <= trace_value_ff;
                tpo_pkg::ADDR_INS_STATUS:  rdata_ff <= trace_out_ff;
                default:                   rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // The device makes the port clock by dividing its own clock; it is one
    // domain, so the port edges are simply counter events.
    always_ff @(posedge clk) begin
        if (rst) begin
            div_ff  <= 8'h00;
            pclk_ff <= 1'b0;
        end else if (div_ff == 8'(CLK_DIV - 1)) begin
            div_ff  <= 8'h00;
            pclk_ff <= ~pclk_ff;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    assign rise_tick = (div_ff == 8'(CLK_DIV - 1)) & ~pclk_ff;

    ////////////////////////////////////////////////////////////////////////
    // Port period counter; markers stand high for period zero of a slot.
    always_ff @(posedge clk) begin
        if (rst) begin
            period_ff <= 8'h00;
            slot_ff   <= 1'b0;
        end else if (rise_tick) begin
            if (period_ff == 8'(SLOT_PERIODS - 1)) begin
                period_ff <= 8'h00;
                slot_ff   <= 1'b1;
            end else begin
                period_ff <= period_ff + 8'h01;
                slot_ff   <= 1'b0;
            end
        end
    end

    assign link.overhead_port_clock   = pclk_ff;
    assign link.overhead_slot_enable  = slot_ff;
    assign link.overhead_frame_marker = slot_ff;

    ////////////////////////////////////////////////////////////////////////
    // Serial input is a pin, so it is resynchronised before sampling.
    // The rise tick is delayed by the same two cycles, so the bit taken is
    // the pin's value at the port clock rise and not an older one.
    always_ff @(posedge clk) begin
        if (rst) begin
            sin_sync_ff <= 2'h0;
            cap_dly_ff  <= 2'h0;
        end else begin
            sin_sync_ff <= {sin_sync_ff[0], link.overhead_serial_in};
            cap_dly_ff  <= {cap_dly_ff[0], rise_tick};
        end
    end

    assign cap_tick     = cap_dly_ff[1];
    assign label_serial = path_ctrl0_ff[tpo_pkg::LABEL_SRC_BIT];
    assign label_last   = 5'(tpo_pkg::LABEL_WAIT_PERIODS
                          + tpo_pkg::BITS_PER_BYTE);

    ////////////////////////////////////////////////////////////////////////
    // Rise number since the marker slot; it saturates so that idle rises
    // late in a long slot never look like a byte position.
    always_ff @(posedge clk) begin
        if (rst) begin
            bitpos_ff <= 5'h1F;
        end else if (rise_tick) begin
            if (slot_ff) begin
                bitpos_ff <= 5'h01;
            end else if (bitpos_ff != 5'h1F) begin
                bitpos_ff <= bitpos_ff + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture one bit per rise; the byte is taken whole at its last rise,
    // so bits of different frames are never mixed.
    always_ff @(posedge clk) begin
        if (rst) begin
            shreg_ff        <= 8'h00;
            serial_trace_ff <= 8'h00;
            serial_label_ff <= 8'h00;
        end else if (cap_tick) begin
            shreg_ff <= {shreg_ff[6:0], sin_sync_ff[1]};
            if (bitpos_ff == 5'(tpo_pkg::BITS_PER_BYTE) && !label_serial) begin
                serial_trace_ff <= {shreg_ff[6:0], sin_sync_ff[1]};
            end
            if (bitpos_ff == label_last && label_serial) begin
                serial_label_ff <= {shreg_ff[6:0], sin_sync_ff[1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-SPE byte selection, latched once per slot so a byte never
    // changes mid-frame.
    always_ff @(posedge clk) begin
        if (rst) begin
            trace_out_ff <= 8'h00;
            label_out_ff <= 8'h00;
            upd_ff       <= 1'b0;
        end else begin
            upd_ff <= rise_tick & slot_ff;
            if (rise_tick && slot_ff) begin
                case (trace_ctrl_ff[1:0])
                    tpo_pkg::TRACE_SRC_ZERO:   trace_out_ff <= 8'h00;
                    tpo_pkg::TRACE_SRC_BUFFER:
                        trace_out_ff <= trace_buffer_byte;
                    tpo_pkg::TRACE_SRC_REG:    trace_out_ff <= trace_value_ff;
                    tpo_pkg::TRACE_SRC_SERIAL: trace_out_ff <= serial_trace_ff;
                    default:                   trace_out_ff <= 8'h00;
                endcase
                label_out_ff <= label_serial ? serial_label_ff
                                             : label_value_ff;
            end
        end
    end

    assign spe_trace_byte = trace_out_ff;
    assign spe_label_byte = label_out_ff;
    assign spe_update     = upd_ff;

endmodule : tpo_device

// ### test/tpo_link_asserts.sv
`timescale 1ns/10ps
module tpo_link_asserts #(
    parameter int CLK_DIV      = 4,
    parameter int SLOT_PERIODS = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic overhead_port_clock,
    input wire logic overhead_slot_enable,
    input wire logic overhead_frame_marker,
    input wire logic overhead_serial_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Port rises since the last marker; the first marker only arms the count.
    logic [15:0] rise_cnt_ff;
    logic        armed_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            rise_cnt_ff <= 16'h0000;
        end else if ($rose(overhead_slot_enable)) begin
            rise_cnt_ff <= 16'h0000;
        end else if ($rose(overhead_port_clock)) begin
            rise_cnt_ff <= rise_cnt_ff + 16'h0001;
        end
    end
    // The gap from reset to the first marker is not a slot spacing.
    always_ff @(posedge clk) begin
        if (rst) begin
            armed_ff <= 1'b0;
        end else if ($rose(overhead_slot_enable)) begin
            armed_ff <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Phases are four system cycles, as the bench runs the divider at four.
    sequence high_phase;
        overhead_port_clock [*4] ##1 !overhead_port_clock;
    endsequence
    sequence low_phase;
        !overhead_port_clock [*4] ##1 overhead_port_clock;
    endsequence
    sequence slot_open;
        overhead_slot_enable [*8] ##1 !overhead_slot_enable;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    clk_high_a: assert property (
        $rose(overhead_port_clock) |-> high_phase)
        else $error("port clock high phase wrong");
    clk_low_a: assert property (
        $fell(overhead_port_clock) |-> low_phase)
        else $error("port clock low phase wrong");
    marks_paired_a: assert property (
        overhead_slot_enable == overhead_frame_marker)
        else $error("slot enable and frame marker differ");
    mark_on_rise_a: assert property (
        $changed(overhead_frame_marker) |-> $rose(overhead_port_clock))
        else $error("marker moved off a port rise");
    mark_width_a: assert property (
        $rose(overhead_slot_enable) |-> slot_open)
        else $error("marker not one port period wide");
    slot_gap_a: assert property (
        $rose(overhead_slot_enable) && armed_ff
            |-> rise_cnt_ff == SLOT_PERIODS - 1)
        else $error("marker spacing wrong");
    data_low_a: assert property (
        $changed(overhead_serial_in) |-> !overhead_port_clock)
        else $error("serial data moved while port clock high");
    data_setup_a: assert property (
        $rose(overhead_port_clock) |-> $stable(overhead_serial_in))
        else $error("serial data moved at capture edge");
endmodule : tpo_link_asserts

// ### test/tx_path_overhead_j1_c2_insert_test.sv
`timescale 1ns/10ps
module tx_path_overhead_j1_c2_insert_test;
    logic        clk;
    logic        rst;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [7:0]  trace_buffer_byte;
    logic [7:0]  spe_trace_byte;
    logic [7:0]  spe_label_byte;
    logic        spe_update;
    logic [7:0]  far_trace;
    logic [7:0]  far_label;
    logic        label_serial_en;
    logic [7:0]  exp_tab [4];
    int          miscompares;
    int          checks_done;
    tpo_link_if  link ();
    ////////////////////////////////////////////////////////////////////////
    tpo_device #(.CLK_DIV(4), .SLOT_PERIODS(32)) u_tpo_device (
        .clk(clk), .rst(rst), .link(link), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .trace_buffer_byte(trace_buffer_byte),
        .spe_trace_byte(spe_trace_byte), .spe_label_byte(spe_label_byte),
        .spe_update(spe_update));
    tpo_far_inserter u_tpo_far_inserter (
        .clk(clk), .rst(rst), .link(link), .trace_byte(far_trace),
        .label_byte(far_label), .label_serial_en(label_serial_en),
        .byte_done());
    tpo_link_asserts #(.CLK_DIV(4), .SLOT_PERIODS(32)) u_tpo_link_asserts (
        .clk(clk), .rst(rst),
        .overhead_port_clock(link.overhead_port_clock),
        .overhead_slot_enable(link.overhead_slot_enable),
        .overhead_frame_marker(link.overhead_frame_marker),
        .overhead_serial_in(link.overhead_serial_in));
    // Free-running system clock, 40 ns period.
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // One place for every comparison, so the counts stay honest.
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reg_write(logic [15:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write
    // Read data stand only in the cycle after the strobe.
    task automatic read_check(logic [15:0] a, logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask : read_check
    task automatic wait_update();
        do @(negedge clk); while (spe_update !== 1'b1);
    endtask : wait_update
    // Bytes land one slot late, so let the pipe flush before comparing twice.
    task automatic settle(logic [7:0] exp_trace, logic [7:0] exp_label);
        repeat (3) wait_update();
        check("spe_trace_byte", spe_trace_byte, exp_trace);
        check("spe_label_byte", spe_label_byte, exp_label);
        wait_update();
        check("spe_trace_byte", spe_trace_byte, exp_trace);
        check("spe_label_byte", spe_label_byte, exp_label);
    endtask : settle
    task automatic end_of_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////
    // Main sequence of register and link checks.
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        trace_buffer_byte = 8'hC3;
        far_trace = 8'h96;
        far_label = 8'hE1;
        label_serial_en = 1'b0;
        miscompares = 0;
        checks_done = 0;
        exp_tab = '{8'h00, 8'hC3, 8'h3C, 8'h96};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        read_check(tpo_pkg::ADDR_LABEL_VALUE, 8'h00);
        read_check(tpo_pkg::ADDR_PATH_CTRL0, 8'h00);
        reg_write(tpo_pkg::ADDR_LABEL_VALUE, 8'h5A);
        read_check(tpo_pkg::ADDR_LABEL_VALUE, 8'h5A);
        reg_write(tpo_pkg::ADDR_LABEL_VALUE, 8'hA5);
        read_check(tpo_pkg::ADDR_LABEL_VALUE, 8'hA5);
        reg_write(tpo_pkg::ADDR_PATH_CTRL0, 8'hFF);
        read_check(tpo_pkg::ADDR_PATH_CTRL0, 8'hFD);
        reg_write(tpo_pkg::ADDR_PATH_CTRL0, 8'h00);
        reg_write(tpo_pkg::ADDR_TRACE_CTRL, 8'hFF);
        read_check(tpo_pkg::ADDR_TRACE_CTRL, 8'h0F);
        read_check(16'h1234, 8'h00);
        reg_write(tpo_pkg::ADDR_TRACE_VALUE, 8'h3C);
        // Every trace selector code in turn, label from its register.
        for (int i = 0; i < 4; i++) begin
            reg_write(tpo_pkg::ADDR_TRACE_CTRL, 8'(i));
            settle(exp_tab[i], 8'hA5);
        end
        // A new serial byte replaces the old one whole.
        @(posedge clk);
        far_trace <= 8'h69;
        settle(8'h69, 8'hA5);
        reg_write(tpo_pkg::ADDR_TRACE_CTRL, 8'h02);
        label_serial_en <= 1'b1;
        reg_write(tpo_pkg::ADDR_PATH_CTRL0, 8'h04);
        settle(8'h3C, 8'hE1);
        @(posedge clk);
        label_serial_en <= 1'b0;
        reg_write(tpo_pkg::ADDR_PATH_CTRL0, 8'h00);
        settle(8'h3C, 8'hA5);
        read_check(tpo_pkg::ADDR_TRACE_VALUE, 8'h3C);
        read_check(tpo_pkg::ADDR_INS_STATUS, 8'h3C);
        end_of_test();
    end
    // Tests need under 7500 cycles; cut a hang well beyond that.
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule : tx_path_overhead_j1_c2_insert_test
